// ==== shared/stseq_pkg.sv ====
// stseq_pkg: constants and types for the source transfer sequencer
`default_nettype none
package stseq_pkg;
  localparam int VW            = 12;
  localparam int DW            = 16;
  localparam int EV_AW         = 4;
  localparam int CLK_PERIOD_NS = 5;
  localparam int MS_NS         = 1000000;
  localparam int TICK_CYCLES   = MS_NS / CLK_PERIOD_NS;
  localparam int TICK_W        = 18;
  // parameter table indices
  localparam int PAR_N         = 6;
  localparam int PAR_LOSS_THR  = 0;
  localparam int PAR_UNB_THR   = 1;
  localparam int PAR_CONF_MS   = 2;
  localparam int PAR_RET_MS    = 3;
  localparam int PAR_FLAGS     = 4;
  localparam int PAR_CAL_REF   = 5;
  // characteristic flag bits
  localparam int FLG_AUTO_RET  = 0;
  localparam int FLG_CLOSED_TR = 1;
  localparam int FLG_UNB_EN    = 2;
  localparam logic [DW-1:0] RST_LOSS_THR = 16'h0800;
  localparam logic [DW-1:0] RST_UNB_THR  = 16'h0100;
  localparam logic [DW-1:0] RST_CONF_MS  = 16'h0064;
  localparam logic [DW-1:0] RST_RET_MS   = 16'h0BB8;
  localparam logic [DW-1:0] RST_FLAGS    = 16'h0001;
  localparam logic [DW-1:0] RST_CAL_REF  = 16'h0A00;
  // access code value is arbitrary
  localparam logic [DW-1:0] ACCESS_CODE  = 16'h5A5A;
  localparam logic [DW-1:0] TEST_PATTERN = 16'hFFFF;
  // confirmation timer slots
  localparam int TM_LOSS = 0;
  localparam int TM_UNB  = 1;
  localparam int TM_RET  = 2;
  localparam int TM_ALTF = 3;
  localparam int TM_N    = 4;
  // examine selector items
  localparam logic [3:0] EX_DIN  = 4'hC;
  localparam logic [3:0] EX_DOUT = 4'hD;

  typedef enum logic [2:0] {
    KEY_MENU  = 3'h0,
    KEY_ENTER = 3'h1,
    KEY_CODE  = 3'h2,
    KEY_EXIT  = 3'h3,
    KEY_EVENT = 3'h4,
    KEY_EXAM  = 3'h5,
    KEY_CAL   = 3'h6,
    KEY_TEST  = 3'h7
  } stseq_key_t;

  typedef enum logic [2:0] {
    DM_IDLE  = 3'h0,
    DM_MENU  = 3'h1,
    DM_EVENT = 3'h2,
    DM_EXAM  = 3'h3,
    DM_TEST  = 3'h4
  } stseq_disp_t;

  typedef enum logic [3:0] {
    ST_NORM = 4'h0,
    ST_XO   = 4'h1,
    ST_XC   = 4'h2,
    ST_ALT  = 4'h3,
    ST_RO   = 4'h4,
    ST_RC   = 4'h5,
    ST_PC   = 4'h6,
    ST_PO   = 4'h7,
    ST_MAN  = 4'h8
  } stseq_state_t;
endpackage : stseq_pkg
`default_nettype wire

// ==== design/stseq_event_mem.sv ====
// stseq_event_mem: event record store with registered read data
`default_nettype none
module stseq_event_mem (
  input  wire logic                      ref_clk_i,
  input  wire logic                      we_i,
  input  wire logic [stseq_pkg::EV_AW-1:0] waddr_i,
  input  wire logic [stseq_pkg::DW-1:0]  wdata_i,
  input  wire logic [stseq_pkg::EV_AW-1:0] raddr_i,
  output logic      [stseq_pkg::DW-1:0]  rdata_o
);
  logic [stseq_pkg::DW-1:0] mem [2**stseq_pkg::EV_AW];

  always_ff @(posedge ref_clk_i) begin
    if (we_i) begin
      mem[waddr_i] <= wdata_i;
    end
    rdata_o <= mem[raddr_i];
  end
endmodule : stseq_event_mem
`default_nettype wire

// ==== design/stseq_top.sv ====
// stseq_top: two-source transfer sequencer with panel and event log
`default_nettype none
module stseq_top #(
  parameter int TICK_CYCLES = stseq_pkg::TICK_CYCLES
) (
  input  wire logic                          ref_clk_i,
  input  wire logic                          rstn_i,
  input  wire logic [2:0][stseq_pkg::VW-1:0] v_src0_i,
  input  wire logic [2:0][stseq_pkg::VW-1:0] v_src1_i,
  input  wire logic [2:0][stseq_pkg::VW-1:0] i_src0_i,
  input  wire logic [2:0][stseq_pkg::VW-1:0] i_src1_i,
  input  wire logic                          pref_sel_i,
  input  wire logic [1:0]                    sw_closed_i,
  input  wire logic [1:0]                    coupled_i,
  input  wire logic [1:0]                    sel_operating_i,
  input  wire logic                          wiring_ok_i,
  input  wire logic                          auto_mode_i,
  input  wire logic [1:0]                    pb_open_i,
  input  wire logic [1:0]                    pb_close_i,
  input  wire logic                          manual_retx_i,
  input  wire logic [1:0]                    test_loss_i,
  input  wire logic                          key_stb_i,
  input  wire logic [2:0]                    key_code_i,
  input  wire logic [stseq_pkg::DW-1:0]      key_data_i,
  output logic      [1:0]                    trip_open_o,
  output logic      [1:0]                    trip_close_o,
  output logic      [1:0]                    src_lamp_o,
  output logic                               ready_lamp_o,
  output logic                               event_lamp_o,
  output logic                               unlocked_o,
  output logic      [2:0]                    disp_mode_o,
  output logic      [stseq_pkg::DW-1:0]      disp_data_o
);
  localparam int VW = stseq_pkg::VW;
  localparam int DW = stseq_pkg::DW;

  function automatic logic [VW-1:0] corr(input logic [VW-1:0] raw,
                                         input logic signed [VW:0] off);
    logic signed [VW+1:0] s;
    s = $signed({2'b00, raw}) + (VW+2)'(off);
    if (s < 0) corr = '0;
    else if (s > $signed((VW+2)'({VW{1'b1}}))) corr = {VW{1'b1}};
    else corr = s[VW-1:0];
  endfunction : corr

  logic [DW-1:0]            par [stseq_pkg::PAR_N];
  logic [2:0]               par_idx;
  logic signed [VW:0]       cal_off [2];
  logic [VW-1:0]            vc [2][3];
  logic [VW-1:0]            v2 [2];
  logic [1:0]               src_ok;
  logic [1:0]               unbal;
  localparam int TICK_W_L = stseq_pkg::TICK_W;
  logic [TICK_W_L-1:0]      tick_cnt;
  logic                     tick;
  logic [stseq_pkg::TM_N-1:0] tm_cond;
  logic [stseq_pkg::TM_N-1:0] tm_done;
  logic [DW-1:0]            tm_cnt [stseq_pkg::TM_N];
  stseq_pkg::stseq_state_t  state;
  stseq_pkg::stseq_state_t  next_state;
  stseq_pkg::stseq_disp_t   dmode;
  logic                     pi;
  logic                     ai;
  logic [1:0]               next_open;
  logic [1:0]               next_close;
  logic                     pb_act;
  logic                     ev_we;
  logic [stseq_pkg::EV_AW-1:0] ev_wp;
  logic [stseq_pkg::EV_AW-1:0] ev_rp;
  logic [DW-1:0]            ev_rd;
  logic [5:0]               not_ready;
  logic [3:0]               ex_sel;
  logic                     key_ok;
  logic                     flg_ar;
  logic                     flg_ct;
  logic                     flg_ue;

  assign pi     = pref_sel_i;
  assign ai     = ~pref_sel_i;
  assign flg_ar = par[stseq_pkg::PAR_FLAGS][stseq_pkg::FLG_AUTO_RET];
  assign flg_ct = par[stseq_pkg::PAR_FLAGS][stseq_pkg::FLG_CLOSED_TR];
  assign flg_ue = par[stseq_pkg::PAR_FLAGS][stseq_pkg::FLG_UNB_EN];
  assign key_ok = key_stb_i;

  // corrected voltages, source quality and unbalance estimate
  always_comb begin
    logic [VW-1:0] mx;
    logic [VW-1:0] mn;
    mx = '0;
    mn = '0;
    for (int s = 0; s < 2; s++) begin
      for (int p = 0; p < 3; p++) begin
        vc[s][p] = corr(s == 0 ? v_src0_i[p] : v_src1_i[p], cal_off[s]);
      end
      mx = vc[s][0];
      mn = vc[s][0];
      for (int p = 1; p < 3; p++) begin
        if (vc[s][p] > mx) mx = vc[s][p];
        if (vc[s][p] < mn) mn = vc[s][p];
      end
      v2[s]     = mx - mn;
      unbal[s]  = flg_ue && ({4'h0, v2[s]} > par[stseq_pkg::PAR_UNB_THR]);
      src_ok[s] = !test_loss_i[s] && !unbal[s] &&
                  ({4'h0, mn} >= par[stseq_pkg::PAR_LOSS_THR]);
    end
  end

  // millisecond time base
  always_ff @(posedge ref_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      tick_cnt <= '0;
      tick     <= 1'b0;
    end else begin
      tick     <= (tick_cnt == TICK_W_L'(TICK_CYCLES - 1));
      tick_cnt <= (tick_cnt == TICK_W_L'(TICK_CYCLES - 1)) ? '0 :
                  tick_cnt + 1'b1;
    end
  end

  assign tm_cond[stseq_pkg::TM_LOSS] = !src_ok[pi] && !unbal[pi];
  assign tm_cond[stseq_pkg::TM_UNB]  = unbal[pi];
  assign tm_cond[stseq_pkg::TM_RET]  = src_ok[pi];
  assign tm_cond[stseq_pkg::TM_ALTF] = !src_ok[ai];

  genvar g;
  generate
    for (g = 0; g < stseq_pkg::TM_N; g++) begin : g_tm
      logic [DW-1:0] lim;
      assign lim = (g == stseq_pkg::TM_RET) ? par[stseq_pkg::PAR_RET_MS] :
                   par[stseq_pkg::PAR_CONF_MS];
      assign tm_done[g] = tm_cond[g] && (tm_cnt[g] >= lim);
      always_ff @(posedge ref_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
          tm_cnt[g] <= '0;
        end else if (!tm_cond[g]) begin
          tm_cnt[g] <= '0;
        end else if (tick && tm_cnt[g] < lim) begin
          tm_cnt[g] <= tm_cnt[g] + 1'b1;
        end
      end
      a_timer_restart: assert property (@(posedge ref_clk_i)
        disable iff (!rstn_i) !tm_cond[g] |=> tm_cnt[g] == '0)
        else $error("confirmation timer did not restart");
    end
  endgenerate

  // transfer sequencer
  always_comb begin
    next_state = state;
    next_open  = 2'b00;
    next_close = 2'b00;
    pb_act     = 1'b0;
    case (state)
      stseq_pkg::ST_NORM: begin
        if (!sw_closed_i[pi] && !sw_closed_i[ai]) next_close[pi] = 1'b1;
        if (!sw_closed_i[ai] && src_ok[ai] &&
            (tm_done[stseq_pkg::TM_LOSS] || tm_done[stseq_pkg::TM_UNB]))
          next_state = stseq_pkg::ST_XO;
      end
      stseq_pkg::ST_XO: begin
        next_open[pi] = 1'b1;
        if (!sw_closed_i[pi]) next_state = stseq_pkg::ST_XC;
      end
      stseq_pkg::ST_XC: begin
        if (!sw_closed_i[pi]) next_close[ai] = 1'b1;
        if (sw_closed_i[ai]) next_state = stseq_pkg::ST_ALT;
      end
      stseq_pkg::ST_ALT: begin
        if (tm_done[stseq_pkg::TM_RET]) begin
          if (flg_ar && flg_ct && src_ok[ai])
            next_state = stseq_pkg::ST_PC;
          else if (flg_ar || manual_retx_i || tm_done[stseq_pkg::TM_ALTF])
            next_state = stseq_pkg::ST_RO;
        end
      end
      stseq_pkg::ST_RO: begin
        next_open[ai] = 1'b1;
        if (!sw_closed_i[ai]) next_state = stseq_pkg::ST_RC;
      end
      stseq_pkg::ST_RC: begin
        if (!sw_closed_i[ai]) next_close[pi] = 1'b1;
        if (sw_closed_i[pi]) next_state = stseq_pkg::ST_NORM;
      end
      stseq_pkg::ST_PC: begin
        next_close[pi] = 1'b1;
        if (sw_closed_i[pi]) next_state = stseq_pkg::ST_PO;
      end
      stseq_pkg::ST_PO: begin
        next_open[ai] = 1'b1;
        if (!sw_closed_i[ai]) next_state = stseq_pkg::ST_NORM;
      end
      stseq_pkg::ST_MAN: begin
        // buttons act only while the selector is still at manual
        if (!auto_mode_i) begin
          next_open  = pb_open_i;
          next_close = pb_close_i & ~pb_open_i;
          pb_act     = |pb_open_i || |pb_close_i;
        end
        next_state = (sw_closed_i[ai] && !sw_closed_i[pi]) ?
                     stseq_pkg::ST_ALT : stseq_pkg::ST_NORM;
      end
      default: next_state = stseq_pkg::ST_NORM;
    endcase
    if (!auto_mode_i) begin
      if (state != stseq_pkg::ST_MAN) begin
        next_open  = 2'b00;
        next_close = 2'b00;
      end
      next_state = stseq_pkg::ST_MAN;
    end
    if (next_close == 2'b11) next_close = 2'b00;
  end

  always_ff @(posedge ref_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      state        <= stseq_pkg::ST_MAN;
      trip_open_o  <= 2'b00;
      trip_close_o <= 2'b00;
    end else begin
      state        <= next_state;
      trip_open_o  <= next_open;
      trip_close_o <= next_close;
    end
  end

  a_no_double_close: assert property (@(posedge ref_clk_i)
    disable iff (!rstn_i) trip_close_o != 2'b11)
    else $error("both switches commanded closed");
  a_close_after_open: assert property (@(posedge ref_clk_i)
    disable iff (!rstn_i) state == stseq_pkg::ST_XC && trip_close_o[ai]
      |-> $past(!sw_closed_i[pi]))
    else $error("close issued before open reported");
  a_xfer_confirmed: assert property (@(posedge ref_clk_i)
    disable iff (!rstn_i)
    $past(state) == stseq_pkg::ST_NORM && state == stseq_pkg::ST_XO
      |-> $past(tm_done[stseq_pkg::TM_LOSS] || tm_done[stseq_pkg::TM_UNB]))
    else $error("transfer started without confirmation");
  a_open_first: assert property (@(posedge ref_clk_i)
    disable iff (!rstn_i) state == stseq_pkg::ST_XO && auto_mode_i
      |=> trip_open_o[pi] && !trip_close_o[ai])
    else $error("preferred not opened first");
  a_pb_blocked: assert property (@(posedge ref_clk_i)
    disable iff (!rstn_i) $past(state) != stseq_pkg::ST_MAN &&
      state != stseq_pkg::ST_MAN && state != stseq_pkg::ST_NORM
      && pb_open_i[ai] && !$past(pb_open_i[ai]) |=> !trip_open_o[ai] ||
      $past(state) == stseq_pkg::ST_RO || $past(state) == stseq_pkg::ST_PO)
    else $error("push button acted in automatic mode");
  a_manual_inhibit: assert property (@(posedge ref_clk_i)
    disable iff (!rstn_i) !auto_mode_i |=> state == stseq_pkg::ST_MAN)
    else $error("automatic switching not inhibited");

  // event record: each transfer, retransfer, closed-transition return or push-button operation leaves a status snapshot
  assign ev_we = (next_state != state && (next_state == stseq_pkg::ST_XO ||
                  next_state == stseq_pkg::ST_RO ||
                  next_state == stseq_pkg::ST_PC)) || pb_act;

  always_ff @(posedge ref_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      ev_wp        <= '0;
      event_lamp_o <= 1'b0;
    end else begin
      if (ev_we) ev_wp <= ev_wp + 1'b1;
      if (ev_we) event_lamp_o <= 1'b1;
      else if (key_ok && key_code_i == stseq_pkg::KEY_EVENT)
        event_lamp_o <= 1'b0;
    end
  end

  stseq_event_mem u_evmem (
    .ref_clk_i (ref_clk_i),
    .we_i      (ev_we),
    .waddr_i   (ev_wp),
    .wdata_i   ({state, sw_closed_i, src_ok, coupled_i, sel_operating_i,
                 auto_mode_i, wiring_ok_i, pi, pb_act}),
    .raddr_i   (ev_rp),
    .rdata_o   (ev_rd)
  );

  a_event_lamp: assert property (@(posedge ref_clk_i)
    disable iff (!rstn_i) ev_we |=> event_lamp_o)
    else $error("event lamp not lit");

  // keypad, menus, access code and calibration
  always_ff @(posedge ref_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      par[stseq_pkg::PAR_LOSS_THR] <= stseq_pkg::RST_LOSS_THR;
      par[stseq_pkg::PAR_UNB_THR]  <= stseq_pkg::RST_UNB_THR;
      par[stseq_pkg::PAR_CONF_MS]  <= stseq_pkg::RST_CONF_MS;
      par[stseq_pkg::PAR_RET_MS]   <= stseq_pkg::RST_RET_MS;
      par[stseq_pkg::PAR_FLAGS]    <= stseq_pkg::RST_FLAGS;
      par[stseq_pkg::PAR_CAL_REF]  <= stseq_pkg::RST_CAL_REF;
      par_idx    <= '0;
      unlocked_o <= 1'b0;
      dmode      <= stseq_pkg::DM_IDLE;
      ev_rp      <= '0;
      ex_sel     <= '0;
      cal_off[0] <= '0;
      cal_off[1] <= '0;
    end else if (key_ok) begin
      case (key_code_i)
        stseq_pkg::KEY_MENU: begin
          dmode <= stseq_pkg::DM_MENU;
          if (key_data_i[2:0] < 3'(stseq_pkg::PAR_N)) par_idx <= key_data_i[2:0];
        end
        stseq_pkg::KEY_ENTER: begin
          if (unlocked_o && dmode == stseq_pkg::DM_MENU)
            par[par_idx] <= key_data_i;
        end
        stseq_pkg::KEY_CODE: unlocked_o <= (key_data_i == stseq_pkg::ACCESS_CODE);
        stseq_pkg::KEY_EXIT: begin
          dmode      <= stseq_pkg::DM_IDLE;
          unlocked_o <= 1'b0;
        end
        stseq_pkg::KEY_EVENT: begin
          dmode <= stseq_pkg::DM_EVENT;
          ev_rp <= (dmode == stseq_pkg::DM_EVENT) ? ev_rp - 1'b1 : ev_wp - 1'b1;
        end
        stseq_pkg::KEY_EXAM: begin
          dmode  <= stseq_pkg::DM_EXAM;
          ex_sel <= key_data_i[3:0];
        end
        stseq_pkg::KEY_CAL: begin
          if (unlocked_o)
            cal_off[key_data_i[0]] <= $signed({1'b0,
              par[stseq_pkg::PAR_CAL_REF][VW-1:0]}) - $signed({1'b0,
              key_data_i[0] ? v_src1_i[0] : v_src0_i[0]});
        end
        default: dmode <= stseq_pkg::DM_TEST;
      endcase
    end
  end

  a_locked_params: assert property (@(posedge ref_clk_i)
    disable iff (!rstn_i) key_ok && key_code_i == stseq_pkg::KEY_ENTER &&
      !unlocked_o |=> $stable(par[stseq_pkg::PAR_FLAGS]) &&
      $stable(par[stseq_pkg::PAR_CONF_MS]))
    else $error("parameter changed while locked");

  // lamps and display
  assign not_ready = {!wiring_ok_i, !(&sel_operating_i), !auto_mode_i,
                      !(&coupled_i), sw_closed_i[ai] != (state == stseq_pkg::ST_ALT),
                      sw_closed_i[pi] != (state != stseq_pkg::ST_ALT)};

  always_ff @(posedge ref_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      src_lamp_o   <= 2'b00;
      ready_lamp_o <= 1'b0;
      disp_mode_o  <= '0;
      disp_data_o  <= '0;
    end else begin
      src_lamp_o   <= src_ok | {2{dmode == stseq_pkg::DM_TEST}};
      ready_lamp_o <= (not_ready == '0) || dmode == stseq_pkg::DM_TEST;
      disp_mode_o  <= dmode;
      case (dmode)
        stseq_pkg::DM_MENU:  disp_data_o <= par[par_idx];
        stseq_pkg::DM_EVENT: disp_data_o <= ev_rd;
        stseq_pkg::DM_TEST:  disp_data_o <= stseq_pkg::TEST_PATTERN;
        stseq_pkg::DM_EXAM: begin
          if (ex_sel < 4'h6)
            disp_data_o <= {4'h0, ex_sel < 4'h3 ? vc[0][ex_sel[1:0]] :
                            vc[1][2'(ex_sel - 4'h3)]};
          else if (ex_sel < 4'h9)
            disp_data_o <= {4'h0, i_src0_i[2'(ex_sel - 4'h6)]};
          else if (ex_sel < 4'hC)
            disp_data_o <= {4'h0, i_src1_i[2'(ex_sel - 4'h9)]};
          else if (ex_sel == stseq_pkg::EX_DIN)
            disp_data_o <= {3'h0, auto_mode_i, wiring_ok_i, pi, pb_open_i,
                            pb_close_i, sel_operating_i, coupled_i, sw_closed_i};
          else
            disp_data_o <= {8'h00, trip_open_o, trip_close_o, src_lamp_o,
                            ready_lamp_o, event_lamp_o};
        end
        default: disp_data_o <= {10'h000, not_ready};
      endcase
    end
  end

  a_ready_lamp: assert property (@(posedge ref_clk_i)
    disable iff (!rstn_i) ready_lamp_o && $past(dmode) != stseq_pkg::DM_TEST
      |-> $past(auto_mode_i && wiring_ok_i && (&coupled_i)))
    else $error("ready lamp lit with a condition unmet");
  a_src_lamp: assert property (@(posedge ref_clk_i)
    disable iff (!rstn_i) $past(test_loss_i[0]) && $past(dmode) !=
      stseq_pkg::DM_TEST |-> !src_lamp_o[0])
    else $error("source lamp lit during simulated loss");
endmodule : stseq_top
`default_nettype wire

// ==== dv/stseq_sw_model.sv ====
// stseq_sw_model: stored-energy operator pair driving the switch positions
`default_nettype none
module stseq_sw_model #(
  parameter int DLY = 20
) (
  input  wire logic       ref_clk_i,
  input  wire logic [1:0] trip_open_i,
  input  wire logic [1:0] trip_close_i,
  input  wire logic [1:0] init_i,
  input  wire logic       load_i,
  output logic      [1:0] sw_closed_o
);
  timeunit 1ns;
  timeprecision 1ps;
  int cnt [2];
  always @(posedge ref_clk_i) begin
    for (int k = 0; k < 2; k++) begin
      if (load_i) begin
        sw_closed_o[k] <= init_i[k];
        cnt[k] <= 0;
      end else if (trip_open_i[k] || trip_close_i[k]) begin
        cnt[k] <= cnt[k] + 1;
        // solenoid must be held DLY cycles before the mechanism moves
        if (cnt[k] == DLY) sw_closed_o[k] <= !trip_open_i[k];
      end else begin
        cnt[k] <= 0;
      end
    end
  end
endmodule : stseq_sw_model
`default_nettype wire

// ==== dv/source_transfer_sequencer_tb_top.sv ====
// source_transfer_sequencer_tb_top: self-checking bench for the sequencer
`default_nettype none
module source_transfer_sequencer_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int TK = 10;
  logic ref_clk_i = 1'b0;
  logic rstn_i = 1'b0;
  logic [2:0][11:0] v0, v1, c0, c1;
  logic [1:0] cpl, sop, pbo, pbc, tl, sw, tro, trc, lamp;
  logic pref, wir, auto, retx, stb, rdy, evl, unl, bad;
  logic [2:0] kc, dm;
  logic [15:0] kd, dd;
  logic [31:0] lfsr = 32'hCF06A175;
  int failures = 0;
  int compares = 0;
  int n;
  always #2.5 ref_clk_i = ~ref_clk_i;
  stseq_top #(.TICK_CYCLES(TK)) uut (
    .ref_clk_i(ref_clk_i), .rstn_i(rstn_i), .v_src0_i(v0), .v_src1_i(v1),
    .i_src0_i(c0), .i_src1_i(c1), .pref_sel_i(pref), .sw_closed_i(sw),
    .coupled_i(cpl), .sel_operating_i(sop), .wiring_ok_i(wir),
    .auto_mode_i(auto), .pb_open_i(pbo), .pb_close_i(pbc),
    .manual_retx_i(retx), .test_loss_i(tl), .key_stb_i(stb),
    .key_code_i(kc), .key_data_i(kd), .trip_open_o(tro),
    .trip_close_o(trc), .src_lamp_o(lamp), .ready_lamp_o(rdy),
    .event_lamp_o(evl), .unlocked_o(unl), .disp_mode_o(dm),
    .disp_data_o(dd));
  stseq_sw_model #(.DLY(20)) ops (
    .ref_clk_i(ref_clk_i), .trip_open_i(tro), .trip_close_i(trc),
    .init_i(2'b01), .load_i(!rstn_i), .sw_closed_o(sw));
  // sticky: both closed, or a close while the other switch is still closed
  always @(posedge ref_clk_i)
    if (rstn_i && (&sw || (trc[1] && sw[0]) || (trc[0] && sw[1]))) bad <= 1;
  task automatic results();
    $display("compares %0d failures %0d", compares, failures);
    if (failures == 0 && compares > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : results
  task automatic chk(input logic [15:0] g, e, input string m);
    compares++;
    if (g !== e) begin
      failures++;
      $display("ERROR %0t %s", $time, m);
    end
  endtask : chk
  task automatic cyc(input int k);
    repeat (k) @(negedge ref_clk_i);
  endtask : cyc
  task automatic key(input logic [2:0] c, input logic [15:0] d);
    kc = c;
    kd = d;
    stb = 1'b1;
    cyc(1);
    stb = 1'b0;
    cyc(3);
  endtask : key
  // s selects the trip-open outputs (0) or the switch positions (1)
  task automatic waitv(input int s, input logic [1:0] v, input int lim);
    n = 0;
    while ((s ? sw : tro) !== v && n < lim) begin
      cyc(1);
      n++;
    end
  endtask : waitv
  function automatic logic [31:0] lfsr_next(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr_next
  function automatic logic ok(input logic [2:0][11:0] v);
    int m = v[0];
    for (int k = 1; k < 3; k++) if (v[k] < m) m = v[k];
    return m >= stseq_pkg::RST_LOSS_THR;
  endfunction : ok
  initial begin
    cyc(80000);
    failures++;
    $display("ERROR %0t watchdog expired", $time);
    results();
  end
  initial begin
    {v0, v1} = {6{12'hC00}};
    {c0, c1} = {lfsr, lfsr, 8'h00};
    {cpl, sop, wir, auto} = 6'h3F;
    {pbo, pbc, tl, pref, retx, stb, bad, kc, kd} = '0;
    cyc(6);
    chk({tro, trc, lamp, rdy, evl, unl}, 0, "reset outputs");
    rstn_i = 1'b1;
    cyc(5);
    chk(rdy, 1, "ready lamp");
    chk(lamp, 2'b11, "source lamps");
    chk({tro, trc}, 0, "idle commands");
    key(stseq_pkg::KEY_MENU, 16'h0002);
    chk(dd, stseq_pkg::RST_CONF_MS, "menu value");
    key(stseq_pkg::KEY_ENTER, 16'h0032);
    key(stseq_pkg::KEY_MENU, 16'h0002);
    chk(dd, stseq_pkg::RST_CONF_MS, "locked write");
    key(stseq_pkg::KEY_CODE, stseq_pkg::ACCESS_CODE);
    chk(unl, 1, "unlock");
    key(stseq_pkg::KEY_ENTER, 16'h0064);
    key(stseq_pkg::KEY_EXIT, 16'h0000);
    chk(unl, 0, "relock");
    wir = 1'b0;
    cyc(3);
    chk(rdy, 0, "ready with bad wiring");
    chk(dd[5], 1, "not ready message");
    wir = 1'b1;
    tl = 2'b01;
    cyc(600);
    tl = 2'b00;
    cyc(2);
    tl = 2'b01;
    waitv(0, 2'b01, 1500);
    n = n - stseq_pkg::RST_CONF_MS * TK;
    chk(n >= -10 && n <= 10, 1, "confirm time");
    chk(trc, 0, "close before open");
    waitv(1, 2'b10, 300);
    chk(sw, 2'b10, "transfer done");
    chk(evl, 1, "event lamp");
    tl = 2'b00;
    waitv(0, 2'b10, 31000);
    n = n - stseq_pkg::RST_RET_MS * TK;
    chk(n >= -10 && n <= 10, 1, "return time");
    waitv(1, 2'b01, 300);
    chk(sw, 2'b01, "retransfer done");
    key(stseq_pkg::KEY_EVENT, 16'h0000);
    chk({dm, evl}, {stseq_pkg::DM_EVENT, 1'b0}, "event key");
    key(stseq_pkg::KEY_EXAM, 16'h0006);
    chk(dd, {4'h0, c0[0]}, "examine current");
    key(stseq_pkg::KEY_TEST, 16'h0000);
    chk(dd, stseq_pkg::TEST_PATTERN, "lamp test");
    key(stseq_pkg::KEY_EXIT, 16'h0000);
    auto = 1'b0;
    pbo = 2'b10;
    cyc(3);
    chk(tro, 2'b10, "manual button");
    pbo = 2'b00;
    for (int i = 0; i < 8; i++) begin
      lfsr = lfsr_next(lfsr);
      v1 = {lfsr[11:0], lfsr[23:12], lfsr[31:20]};
      cyc(3);
      chk(lamp[1], ok(v1), "alternate lamp");
    end
    v1 = {3{12'hC00}};
    auto = 1'b1;
    cyc(3);
    pbo = 2'b10;
    cyc(3);
    chk(tro, 2'b00, "button in auto");
    pbo = 2'b00;
    key(stseq_pkg::KEY_CODE, stseq_pkg::ACCESS_CODE);
    key(stseq_pkg::KEY_MENU, 16'h0004);
    key(stseq_pkg::KEY_ENTER, 16'h0000);
    tl = 2'b01;
    waitv(1, 2'b10, 1400);
    tl = 2'b00;
    cyc(31000);
    chk({tro, trc}, 0, "hold return");
    retx = 1'b1;
    waitv(1, 2'b01, 300);
    chk(sw, 2'b01, "manual retransfer");
    chk(bad, 0, "switch overlap");
    results();
  end
endmodule : source_transfer_sequencer_tb_top
`default_nettype wire
